// >>> reset_wake_pkg.sv
// Constants, encodings and timing for the reset status and wake-exit delay logic.
// How it works
// - Leaving primary-idle mode skips the oscillator start-up count.
// - External clock, RC or internal-oscillator targets skip the oscillator start-up count.
// - Every wake waits the CPU-ready interval; with no start-up count, execution starts the cycle after.
// - The CPU-ready interval runs alongside the other wake delays.
// - Waking into a crystal mode from secondary, internal or sleep applies start-up count; primary-ready flag follows.
// - Crystal-with-PLL target adds the PLL lock wait after the start-up count.
// - Internal-oscillator target from secondary or sleep keeps running; stable flag follows.
// - Any reset returns the internal oscillator selection to 1 MHz.
// - Eight reset causes are told apart and reported.
// - Five low status bits are event flags cleared by events; bits 4, 1 and 0 are set by firmware.
// - Bit 7 enables interrupt priority levels; resets to 0.
// - Bit 6 enables brown-out only when config is 01, else reads 0.
// - Bit 5 always reads 0.
// - Bit 4 cleared by reset instruction, set by power-up or firmware.
// - Bit 3 set by power-up, watchdog clear or sleep; cleared by timeout.
// - Bit 2 set by power-up or watchdog clear; cleared by sleep.
// - Power-on flag cleared only by power-on reset, set only by firmware.
// - Bit 0 cleared by brown-out reset, set only by firmware.
// - Holding the reset pin low resets; short pulses are filtered out.
// - The reset pin is never driven by the device.
// - With the pin function disabled the pin is a plain digital input.
package reset_wake_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int CPU_READY_DELAY_NS = 10000;
   localparam int CPU_READY_DELAY_CYC = (CPU_READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OST_CYC = 1024;
   localparam int PLL_LOCK_TIME_US = 2000;
   localparam int PLL_LOCK_TIME_CYC = PLL_LOCK_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int TIOBST_US = 1000;
   localparam int TIOBST_CYC = TIOBST_US * 1000 / CLK_PERIOD_NS;
   localparam int FILTER_NS = 2000;
   localparam int FILTER_CYC = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] ADDR_RCS = 2'h0;
   localparam logic [1:0] ADDR_OSC = 2'h1;
   localparam logic [1:0] ADDR_CAUSE = 2'h2;
   localparam int BIT_INTERRUPT_PRIORITY_ENABLE = 7;
   localparam int BIT_SBOR = 6;
   localparam int BIT_RI = 4;
   localparam int BIT_TO = 3;
   localparam int BIT_PD = 2;
   localparam int BIT_POR = 1;
   localparam int BIT_BOR = 0;
   localparam logic [2:0] FREQ_1MHZ = 3'h4;
   localparam logic [1:0] BOR_SOFT = 2'h1;
   localparam logic [1:0] BOR_NOSLEEP = 2'h2;
   localparam logic [1:0] BOR_ALWAYS = 2'h3;
   typedef enum logic [1:0] {
      SRC_PRIMARY_IDLE = 2'b00, SRC_SECONDARY = 2'b01,
      SRC_INTERNAL = 2'b10, SRC_SLEEP = 2'b11
   } wake_src_e;
   typedef enum logic [2:0] {
      OSC_LOW_POWER_CRYSTAL = 3'b000, OSC_STANDARD_CRYSTAL = 3'b001,
      OSC_HIGH_SPEED_CRYSTAL = 3'b010, OSC_CRYSTAL_WITH_PLL = 3'b011,
      OSC_EXTERNAL_CLOCK = 3'b100, OSC_RC = 3'b101,
      OSC_INTERNAL = 3'b110, OSC_INTERNAL_IO = 3'b111
   } osc_mode_e;
   typedef enum logic [3:0] {
      CAUSE_NONE = 4'h0, CAUSE_POWER_ON = 4'h1, CAUSE_PIN_RUN = 4'h2,
      CAUSE_PIN_MANAGED = 4'h3, CAUSE_WATCHDOG = 4'h4, CAUSE_BROWNOUT = 4'h5,
      CAUSE_INSTR = 4'h6, CAUSE_STACK_FULL = 4'h7, CAUSE_STACK_UNDER = 4'h8
   } cause_e;
   typedef enum logic [1:0] {
      ST_RUN = 2'b00, ST_ASLEEP = 2'b01, ST_WAKE = 2'b10
   } pm_state_e;
endpackage

// >>> reset_wake_control.sv
// Reset status register, reset pin filter and wake-exit delay sequencer.
`timescale 1ns/100ps
module reset_wake_control
   import reset_wake_pkg::*;
#(
   parameter int PLL_LOCK_CYCLES = PLL_LOCK_TIME_CYC,
   parameter int INTERNAL_OSC_SETTLE_CYCLES = TIOBST_CYC,
   parameter int CNT_W = 17
) (
   input wire logic REF_CLK,
   input wire logic SRST,
   input wire logic [1:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic EXT_RESET_PIN_IN,
   output logic EXT_RESET_PIN_OUT,
   output logic EXT_RESET_PIN_OE,
   input wire logic EXT_RESET_PIN_ENABLE,
   input wire logic [1:0] BROWNOUT_CONFIG,
   input wire logic BROWNOUT_EVENT,
   input wire logic WATCHDOG_TIMEOUT,
   input wire logic WATCHDOG_CLEAR_INSTR,
   input wire logic SLEEP_INSTR,
   input wire logic RESET_INSTR,
   input wire logic STACK_FULL,
   input wire logic STACK_UNDERFLOW,
   input wire logic WAKE_EVENT,
   input wire logic [1:0] WAKE_SRC,
   input wire logic [2:0] WAKE_DST,
   output logic CPU_RUN,
   output logic DEVICE_RESET,
   output logic PIN_DIGITAL_IN,
   output logic PRIMARY_READY,
   output logic INTERNAL_OSC_STABLE,
   output logic [2:0] INTERNAL_OSC_FREQ_SEL,
   output logic INT_PRIORITY_EN,
   output logic BROWNOUT_ENABLE,
   output logic [3:0] RESET_CAUSE
);

   function automatic logic is_crystal(input logic [2:0] m);
      is_crystal = (m == OSC_LOW_POWER_CRYSTAL) || (m == OSC_STANDARD_CRYSTAL) ||
                   (m == OSC_HIGH_SPEED_CRYSTAL) || (m == OSC_CRYSTAL_WITH_PLL);
   endfunction

   localparam logic [CNT_W-1:0] CSD_LOAD = CNT_W'(CPU_READY_DELAY_CYC);
   localparam logic [CNT_W-1:0] OST_LOAD = CNT_W'(OST_CYC);
   localparam logic [CNT_W-1:0] PLL_LOAD = CNT_W'(PLL_LOCK_CYCLES);
   localparam logic [CNT_W-1:0] IOB_LOAD = CNT_W'(INTERNAL_OSC_SETTLE_CYCLES);
   localparam logic [7:0] FILT_LOAD = 8'(FILTER_CYC);

   logic pin_meta_q, pin_sync_q;
   logic [7:0] filt_cnt_q;
   logic pin_rst_q;
   logic pin_fall_q;
   pm_state_e state_q;
   logic [CNT_W-1:0] csd_cnt_q, osc_cnt_q, iob_cnt_q;
   logic pll_pend_q, ost_used_q;
   logic interrupt_priority_enable_q, soft_brownout_enable_q, ri_q, to_q, pd_q, por_q, bor_q;
   logic [2:0] freq_q;
   logic ready_q, stable_q;
   cause_e cause_q;
   logic [7:0] rdata_q;
   logic wake_go, osc_done, int_reset, any_reset, wr_rcs, wr_osc;
   logic need_ost, need_pll, need_iob;
   logic [7:0] rcs_view;

   // The pin is asynchronous; only the second stage feeds the filter.
   always_ff @(posedge REF_CLK) begin
      pin_meta_q <= EXT_RESET_PIN_IN;
      pin_sync_q <= pin_meta_q;
   end

   assign PIN_DIGITAL_IN = pin_sync_q;
   assign EXT_RESET_PIN_OUT = 1'b0;
   assign EXT_RESET_PIN_OE = 1'b0;

   always_ff @(posedge REF_CLK) begin
      if (SRST || pin_sync_q || !EXT_RESET_PIN_ENABLE) begin
         filt_cnt_q <= 8'h00;
      end else if (filt_cnt_q != FILT_LOAD) begin
         filt_cnt_q <= filt_cnt_q + 8'h01;
      end
   end

   // A low shorter than the filter window never reaches the reset output.
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         pin_rst_q <= 1'b0;
         pin_fall_q <= 1'b0;
      end else begin
         pin_rst_q <= (filt_cnt_q == FILT_LOAD) && !pin_sync_q && EXT_RESET_PIN_ENABLE;
         pin_fall_q <= (filt_cnt_q == FILT_LOAD - 8'h01) && !pin_sync_q &&
                       EXT_RESET_PIN_ENABLE;
      end
   end

   // A watchdog timeout while asleep is not a reset, and it does not start a wake.
   assign int_reset = RESET_INSTR || STACK_FULL || STACK_UNDERFLOW || BROWNOUT_EVENT ||
                      (WATCHDOG_TIMEOUT && state_q == ST_RUN);
   assign any_reset = int_reset || pin_rst_q;
   assign DEVICE_RESET = any_reset;

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         cause_q <= CAUSE_POWER_ON;
      end else if (pin_fall_q) begin
         cause_q <= (state_q == ST_RUN) ? CAUSE_PIN_RUN : CAUSE_PIN_MANAGED;
      end else if (BROWNOUT_EVENT) begin
         cause_q <= CAUSE_BROWNOUT;
      end else if (WATCHDOG_TIMEOUT && state_q == ST_RUN) begin
         cause_q <= CAUSE_WATCHDOG;
      end else if (RESET_INSTR) begin
         cause_q <= CAUSE_INSTR;
      end else if (STACK_FULL) begin
         cause_q <= CAUSE_STACK_FULL;
      end else if (STACK_UNDERFLOW) begin
         cause_q <= CAUSE_STACK_UNDER;
      end
   end
   assign RESET_CAUSE = cause_q;

   assign wake_go = (state_q == ST_ASLEEP) && WAKE_EVENT && !any_reset;
   assign need_ost = is_crystal(WAKE_DST) && (WAKE_SRC != SRC_PRIMARY_IDLE);
   assign need_pll = (WAKE_DST == OSC_CRYSTAL_WITH_PLL) && (WAKE_SRC != SRC_PRIMARY_IDLE);
   assign need_iob = ((WAKE_DST == OSC_INTERNAL) || (WAKE_DST == OSC_INTERNAL_IO)) &&
                     ((WAKE_SRC == SRC_SECONDARY) || (WAKE_SRC == SRC_SLEEP));
   assign osc_done = (osc_cnt_q == '0) && !pll_pend_q;

   always_ff @(posedge REF_CLK) begin
      if (SRST || any_reset) begin
         state_q <= ST_RUN;
      end else begin
         case (state_q)
            ST_RUN: begin
               if (SLEEP_INSTR) begin
                  state_q <= ST_ASLEEP;
               end
            end
            ST_ASLEEP: begin
               if (wake_go) begin
                  state_q <= ST_WAKE;
               end
            end
            ST_WAKE: begin
               if (csd_cnt_q == '0 && osc_done) begin
                  state_q <= ST_RUN;
               end
            end
            default: state_q <= ST_RUN;
         endcase
      end
   end
   assign CPU_RUN = (state_q == ST_RUN);

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         csd_cnt_q <= '0;
      end else if (wake_go) begin
         csd_cnt_q <= CSD_LOAD;
      end else if (csd_cnt_q != '0) begin
         csd_cnt_q <= csd_cnt_q - CNT_W'(1);
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         osc_cnt_q <= '0;
         pll_pend_q <= 1'b0;
         ost_used_q <= 1'b0;
      end else if (wake_go) begin
         osc_cnt_q <= need_ost ? OST_LOAD : '0;
         pll_pend_q <= need_pll;
         ost_used_q <= need_ost;
      end else if (osc_cnt_q != '0) begin
         osc_cnt_q <= osc_cnt_q - CNT_W'(1);
      end else if (pll_pend_q) begin
         osc_cnt_q <= PLL_LOAD;
         pll_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         iob_cnt_q <= '0;
      end else if (wake_go && need_iob) begin
         iob_cnt_q <= IOB_LOAD;
      end else if (iob_cnt_q != '0) begin
         iob_cnt_q <= iob_cnt_q - CNT_W'(1);
      end
   end

   // Ready flags drop at a wake that restarts their clock and rise when its wait ends.
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         ready_q <= 1'b1;
         stable_q <= 1'b1;
      end else begin
         if (wake_go && need_ost) begin
            ready_q <= 1'b0;
         end else if (state_q == ST_WAKE && osc_done) begin
            ready_q <= 1'b1;
         end
         if (wake_go && need_iob) begin
            stable_q <= 1'b0;
         end else if (iob_cnt_q == CNT_W'(1)) begin
            stable_q <= 1'b1;
         end
      end
   end
   assign PRIMARY_READY = ready_q;
   assign INTERNAL_OSC_STABLE = stable_q;

   assign wr_rcs = WR && (ADDR == ADDR_RCS);
   assign wr_osc = WR && (ADDR == ADDR_OSC);

   always_ff @(posedge REF_CLK) begin
      if (SRST || any_reset) begin
         freq_q <= FREQ_1MHZ;
      end else if (wr_osc) begin
         freq_q <= WDATA[6:4];
      end
   end
   assign INTERNAL_OSC_FREQ_SEL = freq_q;

   always_ff @(posedge REF_CLK) begin
      if (SRST || any_reset) begin
         interrupt_priority_enable_q <= 1'b0;
      end else if (wr_rcs) begin
         interrupt_priority_enable_q <= WDATA[BIT_INTERRUPT_PRIORITY_ENABLE];
      end
   end
   assign INT_PRIORITY_EN = interrupt_priority_enable_q;

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         soft_brownout_enable_q <= (BROWNOUT_CONFIG == BOR_SOFT);
      end else if (BROWNOUT_CONFIG != BOR_SOFT) begin
         soft_brownout_enable_q <= 1'b0;
      end else if (wr_rcs) begin
         soft_brownout_enable_q <= WDATA[BIT_SBOR];
      end
   end
   assign BROWNOUT_ENABLE = (BROWNOUT_CONFIG == BOR_ALWAYS) ||
                            ((BROWNOUT_CONFIG == BOR_NOSLEEP) && state_q != ST_ASLEEP) ||
                            ((BROWNOUT_CONFIG == BOR_SOFT) && soft_brownout_enable_q);

   // event flags
   // Hardware events win over a firmware set in the same cycle, so no event is lost.
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         ri_q <= 1'b1;
         to_q <= 1'b1;
         pd_q <= 1'b1;
         por_q <= 1'b0;
         bor_q <= 1'b0;
      end else begin
         if (RESET_INSTR) begin
            ri_q <= 1'b0;
         end else if (wr_rcs && WDATA[BIT_RI]) begin
            ri_q <= 1'b1;
         end
         if (WATCHDOG_TIMEOUT) begin
            to_q <= 1'b0;
         end else if (WATCHDOG_CLEAR_INSTR || SLEEP_INSTR) begin
            to_q <= 1'b1;
         end
         if (SLEEP_INSTR) begin
            pd_q <= 1'b0;
         end else if (WATCHDOG_CLEAR_INSTR) begin
            pd_q <= 1'b1;
         end
         if (wr_rcs && WDATA[BIT_POR]) begin
            por_q <= 1'b1;
         end
         if (BROWNOUT_EVENT) begin
            bor_q <= 1'b0;
         end else if (wr_rcs && WDATA[BIT_BOR]) begin
            bor_q <= 1'b1;
         end
      end
   end

   assign rcs_view = {interrupt_priority_enable_q, soft_brownout_enable_q, 1'b0, ri_q, to_q, pd_q, por_q, bor_q};

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         rdata_q <= 8'h00;
      end else if (RD) begin
         case (ADDR)
            ADDR_RCS: rdata_q <= rcs_view;
            ADDR_OSC: rdata_q <= {1'b0, freq_q, ready_q, stable_q, 2'b00};
            ADDR_CAUSE: rdata_q <= {4'h0, cause_q};
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign RDATA = rdata_q;

   // Checking helpers: cycles spent in the wake state.
   logic [CNT_W-1:0] age_q;
   always_ff @(posedge REF_CLK) begin
      if (SRST || wake_go) begin
         age_q <= '0;
      end else if (state_q == ST_WAKE) begin
         age_q <= age_q + CNT_W'(1);
      end
   end

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (SRST);

   sequence wake_plain_s;
      wake_go && !need_ost && !need_iob;
   endsequence
   sequence wake_pll_s;
      wake_go && need_pll;
   endsequence

   pin_undriven_a: assert property (!EXT_RESET_PIN_OE)
      else $error("reset pin driven");
   quick_resume_a: assert property ($rose(CPU_RUN) && !ost_used_q |-> age_q == CSD_LOAD + CNT_W'(1))
      else $error("resume not at ready interval");
   min_ready_a: assert property ($rose(CPU_RUN) |-> age_q > CSD_LOAD)
      else $error("resumed before ready interval");
   longest_wait_a: assert property ($rose(CPU_RUN) && ost_used_q |-> age_q > OST_LOAD)
      else $error("resumed before start-up count");
   skip_startup_a: assert property (wake_plain_s |=> osc_cnt_q == '0 && ready_q == $past(ready_q))
      else $error("start-up count applied wrongly");
   idle_skip_a: assert property (wake_go && WAKE_SRC == SRC_PRIMARY_IDLE |=> osc_done)
      else $error("primary idle wake delayed");
   pll_follows_a: assert property (wake_pll_s |=> pll_pend_q && !ready_q ##1 osc_cnt_q != '0)
      else $error("PLL wait missing");
   settle_run_a: assert property (wake_go && need_iob && !need_ost |=> !stable_q ##[1:600] CPU_RUN)
      else $error("settle stalls execution");
   prio_write_a: assert property (wr_rcs && !any_reset |=> interrupt_priority_enable_q == $past(WDATA[BIT_INTERRUPT_PRIORITY_ENABLE]))
      else $error("priority bit not written");
   sbor_gate_a: assert property (BROWNOUT_CONFIG != BOR_SOFT |=> !soft_brownout_enable_q)
      else $error("soft brown-out bit set outside mode");
   bit5_zero_a: assert property (!RDATA[5] || $past(ADDR) != ADDR_RCS)
      else $error("bit 5 reads one");
   instr_flag_a: assert property (RESET_INSTR |=> !ri_q)
      else $error("instruction flag not cleared");
   timeout_flag_a: assert property (WATCHDOG_TIMEOUT |=> !to_q)
      else $error("timeout flag not cleared");
   sleep_flag_a: assert property (SLEEP_INSTR && !WATCHDOG_TIMEOUT |=> !pd_q && to_q)
      else $error("sleep flags wrong");
   por_sticky_a: assert property (!(wr_rcs && WDATA[BIT_POR]) |=> por_q == $past(por_q))
      else $error("power-on flag changed by hardware");
   bor_flag_a: assert property (BROWNOUT_EVENT |=> !bor_q)
      else $error("brown-out flag not cleared");
   pin_filter_a: assert property ($rose(pin_rst_q) |-> $past(filt_cnt_q) == FILT_LOAD)
      else $error("pin reset without full filter window");
   pin_disabled_a: assert property (!EXT_RESET_PIN_ENABLE |=> !pin_rst_q)
      else $error("disabled pin caused reset");
   freq_default_a: assert property (any_reset |=> freq_q == FREQ_1MHZ)
      else $error("frequency not defaulted");

endmodule

// >>> pin_driver.sv
// Behavioural model of the party that holds the external reset pin.
`timescale 1ns/100ps
module pin_driver (
   input wire logic hold_low,
   output logic pin_level
);
   // pin pulled low
   // The board pull-up takes the line high whenever the driver lets go.
   assign pin_level = hold_low ? 1'b0 : 1'b1;
endmodule

// >>> testbench.sv
// Self-checking testbench for the reset status and wake-exit delay block.
`timescale 1ns/100ps
module testbench;
   import reset_wake_pkg::*;
   localparam int PLL = 20;
   localparam int IOS = 10;
   localparam int T_FAST = CPU_READY_DELAY_CYC + 1;
   localparam int T_OST = OST_CYC + 1;
   // The lock wait is loaded one cycle after the start-up count empties, which adds one edge.
   localparam int T_PLL = OST_CYC + PLL + 2;
   logic ref_clk, srst, wr, rd, pin_en, wake_event, hold_low, pin_level;
   logic [1:0] addr, bor_cfg, wake_src;
   logic [2:0] wake_dst;
   logic [7:0] wdata, rdata;
   // Pulse bits: brown-out, timeout, clear, sleep, reset instr, stack full, underflow.
   logic [6:0] pulse_q;
   logic pin_out, pin_oe, cpu_run, dev_rst, pin_dig, pri_rdy, io_stable, interrupt_priority_enable, bor_en;
   logic [2:0] freq;
   logic [3:0] cause;
   int fail_count, check_count;
   logic [1:0] src_tab [9] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h3, 2'h1, 2'h3, 2'h2, 2'h0};
   logic [2:0] dst_tab [9] = '{3'h2, 3'h4, 3'h5, 3'h7, 3'h6, 3'h1, 3'h0, 3'h3, 3'h3};
   int lat_tab [9] = '{T_FAST, T_FAST, T_FAST, T_FAST, T_FAST, T_OST, T_OST, T_PLL, T_FAST};

   reset_wake_control #(.PLL_LOCK_CYCLES(PLL), .INTERNAL_OSC_SETTLE_CYCLES(IOS)) uut (
      .REF_CLK(ref_clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .EXT_RESET_PIN_IN(pin_level), .EXT_RESET_PIN_OUT(pin_out),
      .EXT_RESET_PIN_OE(pin_oe), .EXT_RESET_PIN_ENABLE(pin_en),
      .BROWNOUT_CONFIG(bor_cfg), .BROWNOUT_EVENT(pulse_q[0]),
      .WATCHDOG_TIMEOUT(pulse_q[1]), .WATCHDOG_CLEAR_INSTR(pulse_q[2]),
      .SLEEP_INSTR(pulse_q[3]), .RESET_INSTR(pulse_q[4]), .STACK_FULL(pulse_q[5]),
      .STACK_UNDERFLOW(pulse_q[6]), .WAKE_EVENT(wake_event), .WAKE_SRC(wake_src),
      .WAKE_DST(wake_dst), .CPU_RUN(cpu_run), .DEVICE_RESET(dev_rst),
      .PIN_DIGITAL_IN(pin_dig), .PRIMARY_READY(pri_rdy), .INTERNAL_OSC_STABLE(io_stable),
      .INTERNAL_OSC_FREQ_SEL(freq), .INT_PRIORITY_EN(interrupt_priority_enable), .BROWNOUT_ENABLE(bor_en),
      .RESET_CAUSE(cause)
   );

   pin_driver u_pin (.hold_low(hold_low), .pin_level(pin_level));

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   task automatic results;
      $display("Checks: %0d  Errors: %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask);
      check_count++;
      if ((got & mask) !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h under mask %h", $time, got, exp, mask);
      end
   endtask

   task automatic chk_n(input int got, input int exp);
      check_count++;
      if (got != exp) begin
         fail_count++;
         $display("Error at %0t: took %0d cycles, expected %0d", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample just past that edge.
   task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp, input logic [7:0] mask);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1;
      chk8(rdata, exp, mask);
   endtask

   task automatic fire(input int i);
      @(posedge ref_clk);
      pulse_q[i] <= 1'b1;
      @(posedge ref_clk);
      pulse_q <= '0;
   endtask

   task automatic wake(input logic [1:0] src, input logic [2:0] dst, input int exp);
      int n;
      logic rdy_exp, stab_exp;
      rdy_exp = !(dst <= 3'h3 && src != 2'h0);
      stab_exp = !(dst >= 3'h6 && (src == 2'h1 || src == 2'h3));
      fire(3);
      @(posedge ref_clk);
      wake_src <= src;
      wake_dst <= dst;
      wake_event <= 1'b1;
      @(posedge ref_clk);
      wake_event <= 1'b0;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
         #1;
         if (n == 2) begin
            chk8({7'h0, pri_rdy}, {7'h0, rdy_exp}, 8'h01);
            chk8({7'h0, io_stable}, {7'h0, stab_exp}, 8'h01);
         end
      end while (cpu_run !== 1'b1 && n < 3000);
      chk_n(n, exp);
   endtask

   task automatic cause_chk(input int i, input logic [3:0] exp_c, input logic [7:0] flag);
      wr_reg(ADDR_OSC, 8'h70);
      wr_reg(ADDR_RCS, 8'hd3);
      fire(i);
      repeat (4) @(posedge ref_clk);
      rd_chk(ADDR_CAUSE, {4'h0, exp_c}, 8'h0f);
      rd_chk(ADDR_RCS, 8'h02, flag | 8'h82);
      rd_chk(ADDR_OSC, 8'h40, 8'h70);
      chk8({5'h0, freq}, {5'h0, FREQ_1MHZ}, 8'h07);
      chk8({4'h0, cause}, {4'h0, exp_c}, 8'h0f);
   endtask

   // The pin is held low for len+1 cycles; any device reset is watched for over the first len.
   task automatic pin_pulse(input logic en, input int len, input logic exp_rst);
      logic seen;
      seen = 1'b0;
      @(posedge ref_clk);
      pin_en <= en;
      hold_low <= 1'b1;
      repeat (len) begin
         @(posedge ref_clk);
         #1;
         if (dev_rst === 1'b1) seen = 1'b1;
      end
      chk8({7'h0, seen}, {7'h0, exp_rst}, 8'h01);
      chk8({7'h0, pin_dig}, 8'h00, 8'h01);
      chk8({6'h0, pin_oe, pin_out}, 8'h00, 8'h03);
      @(posedge ref_clk);
      hold_low <= 1'b0;
      repeat (10) @(posedge ref_clk);
      #1;
      chk8({7'h0, pin_dig}, 8'h01, 8'h01);
   endtask

   initial begin
      #1000000;
      fail_count++;
      $display("Error at %0t: run did not finish in time", $time);
      results();
   end

   initial begin
      fail_count = 0;
      check_count = 0;
      srst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 2'h0;
      wdata = 8'h00;
      pin_en = 1'b1;
      hold_low = 1'b0;
      bor_cfg = 2'h1;
      pulse_q = '0;
      wake_event = 1'b0;
      wake_src = 2'h0;
      wake_dst = 3'h0;
      repeat (10) @(posedge ref_clk);
      srst <= 1'b0;
      rd_chk(ADDR_RCS, 8'h5c, 8'hff);
      rd_chk(ADDR_OSC, 8'h4c, 8'hff);
      rd_chk(ADDR_CAUSE, 8'h01, 8'hff);
      rd_chk(2'h3, 8'h00, 8'hff);
      wr_reg(ADDR_RCS, 8'hff);
      rd_chk(ADDR_RCS, 8'hdf, 8'hff);
      chk8({6'h0, interrupt_priority_enable, bor_en}, 8'h03, 8'h03);
      wr_reg(ADDR_RCS, 8'h00);
      rd_chk(ADDR_RCS, 8'h1f, 8'hff);
      chk8({6'h0, interrupt_priority_enable, bor_en}, 8'h00, 8'h03);
      wr_reg(ADDR_RCS, 8'h40);
      @(posedge ref_clk);
      bor_cfg <= 2'h3;
      rd_chk(ADDR_RCS, 8'h00, 8'h40);
      @(posedge ref_clk);
      bor_cfg <= 2'h1;
      for (int k = 0; k < 9; k++) begin
         wake(src_tab[k], dst_tab[k], lat_tab[k]);
      end
      rd_chk(ADDR_RCS, 8'h08, 8'h0c);
      fire(2);
      rd_chk(ADDR_RCS, 8'h0c, 8'h0c);
      @(posedge ref_clk);
      wake_event <= 1'b1;
      @(posedge ref_clk);
      wake_event <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk8({7'h0, cpu_run}, 8'h01, 8'h01);
      cause_chk(0, CAUSE_BROWNOUT, 8'h01);
      cause_chk(1, CAUSE_WATCHDOG, 8'h08);
      cause_chk(4, CAUSE_INSTR, 8'h10);
      cause_chk(5, CAUSE_STACK_FULL, 8'h00);
      cause_chk(6, CAUSE_STACK_UNDER, 8'h00);
      pin_pulse(1'b1, 50, 1'b0);
      pin_pulse(1'b1, 150, 1'b1);
      rd_chk(ADDR_CAUSE, {4'h0, CAUSE_PIN_RUN}, 8'h0f);
      @(posedge ref_clk);
      bor_cfg <= 2'h2;
      fire(3);
      #1;
      chk8({7'h0, bor_en}, 8'h00, 8'h01);
      pin_pulse(1'b1, 150, 1'b1);
      chk8({7'h0, bor_en}, 8'h01, 8'h01);
      rd_chk(ADDR_CAUSE, {4'h0, CAUSE_PIN_MANAGED}, 8'h0f);
      pin_pulse(1'b0, 150, 1'b0);
      rd_chk(ADDR_CAUSE, {4'h0, CAUSE_PIN_MANAGED}, 8'h0f);
      results();
   end
endmodule
